// [inc/inhibit_pin_defs.vh]
// Purpose: register map, field positions, reset values and timing for the output inhibit pin block
// Assumes: 20 MHz aclk, AXI4-Lite with 32-bit data
// Notes:   offsets are byte addresses, one aligned word per register
`ifndef INHIBIT_PIN_DEFS_VH
`define INHIBIT_PIN_DEFS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_CTRL        8'h00
`define OFS_OUT_CTRL    8'h04
`define OFS_PWM_PERIOD  8'h08
`define OFS_PWM_DUTY    8'h0C
`define OFS_STATUS      8'h10
`define OFS_IRQ_STATUS  8'h14
`define OFS_IRQ_CLEAR   8'h18
`define OFS_IRQ_ENABLE  8'h1C

// ****************************************************************
// field positions and encodings
// ****************************************************************
`define CTRL_FLIP_BIT     0
`define CTRL_FUNC_LSB     1
`define CTRL_SUBMODE_BIT  3
`define CTRL_ENABLE_BIT   4
`define FUNC_BLOCK        2'h0
`define FUNC_INPUT        2'h1
`define FUNC_OUTPUT       2'h2
`define OVAL_ZERO         2'h0
`define OVAL_ONE          2'h1
`define OVAL_PWM          2'h2
`define ST_LEVEL_BIT      0
`define ST_BLOCKED_BIT    1
`define ST_TRIPPED_BIT    2
`define ST_ENABLE_BIT     3
`define ST_ACTOUT_BIT     4
`define IRQ_BLOCK_BIT     0
`define IRQ_TRIP_BIT      1
`define IRQ_EDGE_BIT      2

// ****************************************************************
// reset values and timing
// ****************************************************************
`define CTRL_RESET        32'h0000_0000
`define PWM_PERIOD_RESET  32'h0000_4E20
`define PWM_DUTY_RESET    32'h0000_2710
`define CLK_MHZ           20
`define TRIP_MIN_NS       30000
`define TRIP_MIN_CYCLES   ((`TRIP_MIN_NS * `CLK_MHZ + 999) / 1000)

`endif

// [design/output_inhibit_io_pin.v]
// Purpose: one multi-function rear-connector pin: output blocking, general input, or 1/0/PWM output
// Assumes: aclk 20 MHz, aresetn synchronous active low, pin input asynchronous to aclk before the synchroniser
// Notes:   software reaches all settings over AXI4-Lite; tri-state pin driven high or low under output enable
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`default_nettype none
`include "inhibit_pin_defs.vh"

module output_inhibit_io_pin (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // pin
  input  wire        pin_in,
  output reg         pin_out,
  output reg         pin_oe,
  // instrument side
  output reg         output_active,
  output reg         blocked_indication,
  output reg         tripped_protection_indication,
  output reg         irq
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  // trip qualifier length, cut to the counter width on purpose, and write-path states
  localparam integer TRIP_FULL = `TRIP_MIN_CYCLES;
  localparam [15:0]  TRIP_CYC  = TRIP_FULL[15:0];
  localparam [2:0]   W_IDLE    = 3'h1;
  localparam [2:0]   W_HAVE    = 3'h2;
  localparam [2:0]   W_RESP    = 3'h4;

  // software settings
  reg  [31:0] ctrl_r;
  reg  [1:0]  out_val_r;
  reg  [31:0] pwm_period_r;
  reg  [31:0] pwm_duty_r;
  // pwm state
  reg  [31:0] pwm_cnt_r;
  reg         pwm_level_r;
  // pin sampling and trip qualifier
  reg         sync1_r;
  reg         sync2_r;
  reg         level_prev_r;
  reg  [15:0] low_cnt_r;
  reg         armed_r;
  // output enable, protection latch and interrupts
  reg         enable_r;
  reg         tripped_r;
  reg  [2:0]  irq_stat_r;
  reg  [2:0]  irq_en_r;
  // write path capture
  reg  [2:0]  wstate_r;
  reg         aw_got_r;
  reg         w_got_r;
  reg  [7:0]  awaddr_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;

  // decoded control fields and pin conditions
  wire        flip     = ctrl_r[`CTRL_FLIP_BIT];
  wire [1:0]  func     = ctrl_r[`CTRL_FUNC_LSB+1:`CTRL_FUNC_LSB];
  wire        sub_trip = ctrl_r[`CTRL_SUBMODE_BIT];
  wire        level    = sync2_r ^ flip;
  wire        hold_on  = (func == `FUNC_BLOCK) && !sub_trip;
  wire        trip_on  = (func == `FUNC_BLOCK) && sub_trip;
  wire        blocking = hold_on && !level;
  wire        trip_evt = trip_on && armed_r && level && !level_prev_r;
  wire        wr_fire  = (wstate_r == W_HAVE);

  // merge a bus write into an old word under byte strobes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (st[k]) begin
          merge[8*k +: 8] = nw[8*k +: 8];
        end
      end
    end
  endfunction

  // decode a word address into a register hit
  function is_reg;
    input [7:0] a;
    input [7:0] ofs;
    begin
      is_reg = (a[7:2] == ofs[7:2]);
    end
  endfunction

  // word index of a byte offset, for the read decoder
  function [5:0] word_idx;
    input [7:0] ofs;
    begin
      word_idx = ofs[7:2];
    end
  endfunction

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  // two stages before any sub-mode logic looks at the pin
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // ****************************************************************
  // pulse-trip qualifier
  // ****************************************************************
  // arms once the pin has stayed at its active-low phase long enough
  always @(posedge aclk) begin
    if (!aresetn) begin
      level_prev_r <= 1'b1;
      low_cnt_r    <= 16'h0000;
      armed_r      <= 1'b0;
    end else begin
      level_prev_r <= level;
      if (level) begin
        low_cnt_r <= 16'h0000;
        if (!level_prev_r) begin
          armed_r <= 1'b0;
        end
      end else if (low_cnt_r < TRIP_CYC) begin
        low_cnt_r <= low_cnt_r + 16'h0001;
      end else begin
        armed_r <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // output enable and protection latch
  // ****************************************************************
  // a trip clears enable and latches protection; only software re-enables
  always @(posedge aclk) begin
    if (!aresetn) begin
      enable_r  <= 1'b0;
      tripped_r <= 1'b0;
    end else begin
      if (trip_evt && enable_r) begin
        enable_r  <= 1'b0;
        tripped_r <= 1'b1;
      end else if (wr_fire && is_reg(awaddr_r, `OFS_CTRL) && wstrb_r[0]) begin
        enable_r  <= wdata_r[`CTRL_ENABLE_BIT] && !tripped_r;
        if (!wdata_r[`CTRL_ENABLE_BIT]) begin
          tripped_r <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // pwm generator
  // ****************************************************************
  // counts one period and is high while below the duty count
  always @(posedge aclk) begin
    if (!aresetn) begin
      pwm_cnt_r   <= 32'h0000_0000;
      pwm_level_r <= 1'b0;
    end else begin
      if (pwm_cnt_r + 32'h0000_0001 >= pwm_period_r) begin
        pwm_cnt_r <= 32'h0000_0000;
      end else begin
        pwm_cnt_r <= pwm_cnt_r + 32'h0000_0001;
      end
      pwm_level_r <= (pwm_cnt_r < pwm_duty_r);
    end
  end

  // ****************************************************************
  // pin drive and instrument outputs
  // ****************************************************************
  // pin level, drive enable and instrument indications, all registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_out                       <= 1'b1;
      pin_oe                        <= 1'b0;
      output_active                 <= 1'b0;
      blocked_indication            <= 1'b0;
      tripped_protection_indication <= 1'b0;
    end else begin
      pin_oe <= (func == `FUNC_OUTPUT);
      case (out_val_r)
        `OVAL_ONE: pin_out <= flip;
        `OVAL_PWM: pin_out <= ~pwm_level_r ^ flip;
        default:   pin_out <= ~flip;
      endcase
      output_active                 <= enable_r && !blocking;
      blocked_indication            <= enable_r && blocking;
      tripped_protection_indication <= tripped_r;
    end
  end

  // ****************************************************************
  // interrupt status
  // ****************************************************************
  // sticky bits; a new event beats a clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= 3'h0;
      irq        <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr_fire && is_reg(awaddr_r, `OFS_IRQ_CLEAR)) ? wdata_r[2:0] : 3'h0))
                  | {level ^ level_prev_r, trip_evt && enable_r, blocking && enable_r};
      irq        <= |(irq_stat_r & irq_en_r);
    end
  end

  // ****************************************************************
  // axi4-lite write path
  // ****************************************************************
  // captures address and data, updates the registers, then answers
  always @(posedge aclk) begin
    if (!aresetn) begin
      wstate_r      <= W_IDLE;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      ctrl_r        <= `CTRL_RESET;
      out_val_r     <= `OVAL_ZERO;
      pwm_period_r  <= `PWM_PERIOD_RESET;
      pwm_duty_r    <= `PWM_DUTY_RESET;
      irq_en_r      <= 3'h0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      case (wstate_r)
        W_IDLE: begin
          // address and data are taken independently, in either order
          if (s_axi_awvalid && !aw_got_r && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
            awaddr_r      <= s_axi_awaddr;
            aw_got_r      <= 1'b1;
          end
          if (s_axi_wvalid && !w_got_r && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
            wdata_r      <= s_axi_wdata;
            wstrb_r      <= s_axi_wstrb;
            w_got_r      <= 1'b1;
          end
          if (aw_got_r && w_got_r) begin
            wstate_r <= W_HAVE;
          end
        end
        W_HAVE: begin
          // registers update here, in the same cycle that bvalid rises
          if (is_reg(awaddr_r, `OFS_CTRL)) begin
            ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) & 32'h0000_000F;
          end
          if (is_reg(awaddr_r, `OFS_OUT_CTRL) && wstrb_r[0]) begin
            out_val_r <= wdata_r[1:0];
          end
          if (is_reg(awaddr_r, `OFS_PWM_PERIOD)) begin
            pwm_period_r <= merge(pwm_period_r, wdata_r, wstrb_r);
          end
          if (is_reg(awaddr_r, `OFS_PWM_DUTY)) begin
            pwm_duty_r <= merge(pwm_duty_r, wdata_r, wstrb_r);
          end
          if (is_reg(awaddr_r, `OFS_IRQ_ENABLE) && wstrb_r[0]) begin
            irq_en_r <= wdata_r[2:0];
          end
          s_axi_bresp  <= (awaddr_r > `OFS_IRQ_ENABLE + 8'h03) ? 2'h2 : 2'h0;
          s_axi_bvalid <= 1'b1;
          wstate_r     <= W_RESP;
        end
        W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            wstate_r     <= W_IDLE;
          end
        end
        default: wstate_r <= W_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // axi4-lite read path
  // ****************************************************************
  // one read at a time; data stands until rready is seen
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= 2'h0;
        s_axi_rdata   <= 32'h0000_0000;
        case (s_axi_araddr[7:2])
          word_idx(`OFS_CTRL):       s_axi_rdata <= {27'h0, enable_r, ctrl_r[3:0]};
          word_idx(`OFS_OUT_CTRL):   s_axi_rdata <= {30'h0, out_val_r};
          word_idx(`OFS_PWM_PERIOD): s_axi_rdata <= pwm_period_r;
          word_idx(`OFS_PWM_DUTY):   s_axi_rdata <= pwm_duty_r;
          word_idx(`OFS_STATUS):     s_axi_rdata <= {27'h0, output_active, enable_r, tripped_r, blocking && enable_r,
                                                     level};
          word_idx(`OFS_IRQ_STATUS): s_axi_rdata <= {29'h0, irq_stat_r};
          word_idx(`OFS_IRQ_CLEAR):  s_axi_rdata <= 32'h0000_0000;
          word_idx(`OFS_IRQ_ENABLE): s_axi_rdata <= {29'h0, irq_en_r};
          default:                   s_axi_rresp <= 2'h2;
        endcase
      end
    end
  end

endmodule // output_inhibit_io_pin
`default_nettype wire

// [testbench/inhibit_pin_assertions.sv]
// Purpose: port-level checks for the output inhibit pin block
// Assumes: one aclk domain, aresetn synchronous active low, 32-bit writes with all byte lanes
// Notes:   control word is shadowed from write beats aimed at the control offset
`default_nettype none
`include "inhibit_pin_defs.vh"
module inhibit_pin_assertions (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register writes
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  // pin and instrument side
  input wire logic        pin_in,
  input wire logic        pin_oe,
  input wire logic        output_active,
  input wire logic        blocked_indication,
  input wire logic        tripped_protection_indication
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] ctrl_r;
  logic [9:0] low_r;
  logic [9:0] last_r;
  logic       lvl;
  logic       act;
  // control shadow and length of the latest low run on the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= 5'h00;
      low_r  <= 10'h000;
      last_r <= 10'h000;
    end else begin
      if (s_axi_wvalid && s_axi_wready && s_axi_awaddr == `OFS_CTRL)
        ctrl_r <= s_axi_wdata[4:0];
      if (pin_in)
        low_r <= 10'h000;
      else if (low_r != 10'h3FF)
        low_r <= low_r + 10'h001;
      if (pin_in && low_r != 10'h000)
        last_r <= low_r;
    end
  end
  // level-hold armed, and pin at its blocking level after polarity
  assign lvl = ctrl_r[2:1] == `FUNC_BLOCK && !ctrl_r[3] && ctrl_r[4] && !tripped_protection_indication;
  assign act = !(pin_in ^ ctrl_r[0]);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************************************************
  // assertions
  // ****************************************************************
  a_trip_min_width:
    assert property ($rose(tripped_protection_indication) && !ctrl_r[0] |-> last_r >= 10'h258)
    else $error("trip after a too short pulse");
  a_trip_output_off:
    assert property (tripped_protection_indication |-> !output_active)
    else $error("output on while tripped");
  a_trip_needs_enable:
    assert property ($rose(tripped_protection_indication) |-> $past(output_active))
    else $error("trip without output on");
  a_trip_held:
    assert property ($fell(tripped_protection_indication) |-> !ctrl_r[4])
    else $error("trip latch dropped by itself");
  a_block_forces_zero:
    assert property ((lvl && act) [*5] |-> blocked_indication && !output_active)
    else $error("blocking level did not block");
  a_release_restores:
    assert property ((lvl && !act) [*5] |-> !blocked_indication && output_active)
    else $error("output not restored");
  a_input_no_block:
    assert property ((ctrl_r[2:1] == `FUNC_INPUT && ctrl_r[4] && !tripped_protection_indication) [*5]
                     |-> output_active && !blocked_indication)
    else $error("input function touched the output");
  a_oe_in_output:
    assert property ((ctrl_r[2:1] == `FUNC_OUTPUT) [*4] |-> pin_oe)
    else $error("pin not driven in output function");
  a_oe_off_else:
    assert property ((ctrl_r[2:1] != `FUNC_OUTPUT) [*4] |-> !pin_oe)
    else $error("pin driven outside output function");
  // main scenarios reached
  c_trip: cover property ($rose(tripped_protection_indication));
  c_block: cover property ($rose(blocked_indication));
  c_drive: cover property ($rose(pin_oe));
endmodule // inhibit_pin_assertions

bind output_inhibit_io_pin inhibit_pin_assertions i_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .pin_in, .pin_oe, .output_active, .blocked_indication,
  .tripped_protection_indication);
`default_nettype wire

// [testbench/pin_far_end.sv]
// Purpose: external equipment on the pin, driving levels and pulses
// Assumes: pin has a pull-up, so a released pin reads high
// Notes:   resolves the wire from both drivers and feeds it back to the block
`default_nettype none
module pin_far_end (
  // clock
  input wire logic aclk,
  // block's pin driver
  input wire logic pin_out,
  input wire logic pin_oe,
  // resolved pin level
  output logic     pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv_en = 1'b0;
  logic drv_lvl = 1'b1;
  // block driver first, then the far driver, else the pull-up
  assign pin_in = pin_oe ? pin_out : (drv_en ? drv_lvl : 1'b1);
  // drive a level from just after an edge; low runs for trips last 600 cycles or more
  task automatic drive(input logic lvl);
    @(posedge aclk);
    drv_en  <= 1'b1;
    drv_lvl <= lvl;
  endtask
  // release the pin to the pull-up
  task automatic let_go();
    @(posedge aclk);
    drv_en <= 1'b0;
  endtask
endmodule // pin_far_end
`default_nettype wire

// [testbench/test_output_inhibit_io_pin.sv]
// Purpose: register-driven tests of the output inhibit pin block
// Assumes: aclk 50 ns, reset held 3 cycles, AXI4-Lite master tasks
// Notes:   status read back as a 5-bit word and compared whole
`default_nettype none
`include "inhibit_pin_defs.vh"
module test_output_inhibit_io_pin;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, r, cnt;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        pin_in, pin_out, pin_oe, output_active, blocked_indication, tripped_protection_indication, irq;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  output_inhibit_io_pin i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in,
    .pin_out, .pin_oe, .output_active, .blocked_indication, .tripped_protection_indication, .irq);
  pin_far_end i_far (.aclk, .pin_out, .pin_oe, .pin_in);
  // ****************************************************************
  // helpers
  // ****************************************************************
  initial forever #25 aclk = ~aclk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("FAIL at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // one write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= v;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    while (!s_axi_bvalid) @(posedge aclk);
    r = {30'h0, s_axi_bresp};
    s_axi_bready <= 1'b0;
  endtask
  // one read, data and response left in d and r
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = {30'h0, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task automatic st(input logic [31:0] e);
    rd(`OFS_STATUS);
    chk(d & 32'h0000_001F, e);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog
  initial begin
    tick(20000);
    n_mismatch++;
    end_of_test();
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    tick(3);
    aresetn <= 1'b1;
    rd(`OFS_CTRL);
    chk(d, `CTRL_RESET);
    rd(`OFS_PWM_PERIOD);
    chk(d, `PWM_PERIOD_RESET);
    rd(`OFS_PWM_DUTY);
    chk(d, `PWM_DUTY_RESET);
    rd(8'h20);
    chk(r, 32'h2);
    wr(8'h20, 32'h0);
    chk(r, 32'h2);
    wr(`OFS_IRQ_CLEAR, 32'h7);
    wr(`OFS_IRQ_ENABLE, 32'h1);
    // level-hold, normal then flipped polarity
    wr(`OFS_CTRL, 32'h10);
    st(32'h19);
    i_far.drive(1'b0);
    tick(4);
    st(32'h0A);
    chk({blocked_indication, output_active, irq}, 32'h5);
    i_far.let_go();
    tick(4);
    chk({blocked_indication, output_active}, 32'h1);
    wr(`OFS_IRQ_CLEAR, 32'h1);
    tick(3);
    chk(irq, 32'h0);
    wr(`OFS_CTRL, 32'h11);
    st(32'h0A);
    i_far.drive(1'b0);
    tick(4);
    st(32'h19);
    i_far.let_go();
    // pulse-trip: short pulse ignored, long pulse trips, trip masked then raised
    wr(`OFS_CTRL, 32'h18);
    wr(`OFS_IRQ_ENABLE, 32'h0);
    st(32'h19);
    i_far.drive(1'b0);
    tick(300);
    st(32'h18);
    i_far.let_go();
    tick(4);
    st(32'h19);
    i_far.drive(1'b0);
    tick(610);
    i_far.let_go();
    tick(4);
    st(32'h05);
    chk(tripped_protection_indication, 32'h1);
    chk(irq, 32'h0);
    wr(`OFS_IRQ_ENABLE, 32'h2);
    tick(3);
    chk(irq, 32'h1);
    rd(`OFS_IRQ_STATUS);
    chk(d, 32'h7);
    wr(`OFS_CTRL, 32'h18);
    st(32'h05);
    wr(`OFS_CTRL, 32'h08);
    wr(`OFS_CTRL, 32'h18);
    st(32'h19);
    wr(`OFS_IRQ_CLEAR, 32'h2);
    tick(3);
    chk(irq, 32'h0);
    // general input
    wr(`OFS_CTRL, 32'h12);
    i_far.drive(1'b0);
    tick(4);
    st(32'h18);
    i_far.let_go();
    // general output, values 0 and 1 under both polarities, then PWM under normal polarity only
    for (int f = 0; f < 2; f++) begin
      for (int v = 0; v < 2; v++) begin
        wr(`OFS_CTRL, 32'h4 | f);
        wr(`OFS_OUT_CTRL, v);
        tick(3);
        chk({pin_oe, pin_out}, {1'b1, v[0] ? f[0] : ~f[0]});
      end
    end
    wr(`OFS_CTRL, 32'h4);
    wr(`OFS_PWM_PERIOD, 32'hA);
    wr(`OFS_PWM_DUTY, 32'h4);
    wr(`OFS_OUT_CTRL, `OVAL_PWM);
    tick(3);
    cnt = 32'h0;
    for (int i = 0; i < 20; i++) begin
      @(posedge aclk);
      cnt = cnt + {31'h0, ~pin_out};
    end
    chk(cnt, 32'h8);
    end_of_test();
  end
endmodule // test_output_inhibit_io_pin
`default_nettype wire
